/* rtl/ssp_top.v */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_top (
	input  wire       CLK_SYS,
	input  wire       RST_N,
	input  wire [7:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	input  wire       SLEEPING,
	output reg        WAKE,
	input  wire       SCK_I,
	output reg        SCK_O,
	output reg        SCK_OE,
	input  wire       SDI_I,
	output reg        SDO_O,
	output reg        SDO_OE,
	input  wire       SS_N_I,
	input  wire       SCL_I,
	output reg        SCL_O,
	output reg        SCL_OE,
	input  wire       SDA_I,
	output reg        SDA_O,
	output reg        SDA_OE
);
	reg  [7:0] flags_q;
	reg  [7:0] enables_q;
	reg  [7:0] ctrl_q;
	reg  [7:0] ctrl2_q;
	reg  [7:0] stat_q;
	reg  [7:0] addr_q;
	reg  [7:0] buf_q;
	reg  [1:0] sck_s_q;
	reg  [1:0] sdi_s_q;
	reg  [1:0] ss_s_q;
	reg  [1:0] scl_s_q;
	reg  [1:0] sda_s_q;
	wire [3:0] mode;
	wire       en;
	wire       is_i2c;
	wire       spi_master;
	wire       spi_on;
	wire       ss_reset;
	wire       buf_wr;
	wire       buf_rd;
	wire       spi_sck;
	wire       spi_sdo;
	wire [7:0] spi_rx;
	wire       spi_done;
	wire       i2c_sda_low;
	wire       i2c_start_seen;
	wire       i2c_start_done;
	wire       i2c_coll;
	wire       i2c_in_start;
	wire [7:0] i2c_rx;
	wire       i2c_full;
	wire       i2c_ack;
	wire       i2c_ua;

	function is_addr;
		input [7:0] a;
		input [7:0] off;
		begin
			is_addr = (a == off);
		end
	endfunction

	assign mode = ctrl_q[3:0];
	assign en = ctrl_q[`SSP_CTRL_EN];
	assign is_i2c = mode[3] || (mode[2] && mode[1]);
	assign spi_on = en && !is_i2c;
	// rate field only matters when master
	assign spi_master = !mode[2];
	// slave-select only honoured in mode 0100
	assign ss_reset = spi_on && (mode == `SSP_MODE_S_SS) && ss_s_q[1];
	assign buf_wr = WR && is_addr(ADDR, `SSP_OFF_BUF);
	assign buf_rd = RD && is_addr(ADDR, `SSP_OFF_BUF);

	// pins are asynchronous: two flops before any use
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			sck_s_q <= 2'h0;
			sdi_s_q <= 2'h0;
			ss_s_q <= 2'h3;
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
		end else begin
			sck_s_q <= {sck_s_q[0], SCK_I};
			sdi_s_q <= {sdi_s_q[0], SDI_I};
			ss_s_q <= {ss_s_q[0], SS_N_I};
			scl_s_q <= {scl_s_q[0], SCL_I};
			sda_s_q <= {sda_s_q[0], SDA_I};
		end
	end

	ssp_spi u_spi (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.enable    (spi_on),
		.master    (spi_master),
		.idle_lvl  (ctrl_q[`SSP_CTRL_IDLE]),
		.cke       (stat_q[`SSP_STAT_CKE]),
		.late_smp  (stat_q[`SSP_STAT_LATE]),
		.rate      (mode[1:0]),
		.load      (buf_wr && spi_on && !i2c_in_start),
		.load_data (WDATA),
		.sck_in    (sck_s_q[1]),
		.sdi_in    (sdi_s_q[1]),
		.ss_reset  (ss_reset),
		.sck_out   (spi_sck),
		.sdo_out   (spi_sdo),
		.rx_data   (spi_rx),
		.done      (spi_done)
	);

	ssp_i2c u_i2c (
		.clk        (CLK_SYS),
		.rst_n      (RST_N),
		.enable     (en && is_i2c),
		.ten_bit    (mode[0]),
		.master     (mode == `SSP_MODE_I2C_M),
		.gcall_en   (ctrl2_q[`SSP_CTRL2_GCALL]),
		.addr       (addr_q),
		.start_req  (ctrl2_q[`SSP_CTRL2_START]),
		.scl_in     (scl_s_q[1]),
		.sda_in     (sda_s_q[1]),
		.sda_low    (i2c_sda_low),
		.start_seen (i2c_start_seen),
		.start_done (i2c_start_done),
		.collision  (i2c_coll),
		.in_start   (i2c_in_start),
		.rx_byte    (i2c_rx),
		.byte_full  (i2c_full),
		.ack_irq    (i2c_ack),
		.upd_set    (i2c_ua)
	);

	// register file; hardware sets win over software writes
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			flags_q <= `SSP_RST_FLAGS;
			enables_q <= `SSP_RST_ENABLES;
			ctrl_q <= `SSP_RST_CTRL;
			ctrl2_q <= `SSP_RST_CTRL2;
			stat_q <= `SSP_RST_STAT;
			addr_q <= `SSP_RST_ADDR;
			buf_q <= 8'h00;
			RDATA <= 8'h00;
			WAKE <= 1'b0;
		end else begin
			WAKE <= 1'b0;
			if (WR) begin
				if (is_addr(ADDR, `SSP_OFF_FLAGS))
					flags_q <= WDATA;
				if (is_addr(ADDR, `SSP_OFF_ENABLES))
					enables_q <= WDATA;
				if (is_addr(ADDR, `SSP_OFF_CTRL))
					ctrl_q <= WDATA;
				if (is_addr(ADDR, `SSP_OFF_STAT))
					stat_q[7:6] <= WDATA[7:6];
				if (is_addr(ADDR, `SSP_OFF_ADDR))
					addr_q <= WDATA;
				if (is_addr(ADDR, `SSP_OFF_CTRL2)) begin
					ctrl2_q[7:5] <= WDATA[7:5];
					if (!i2c_in_start)
						ctrl2_q[4:0] <= WDATA[4:0];
				end
				if (buf_wr) begin
					if (i2c_in_start)
						ctrl_q[`SSP_CTRL_WRCOL] <= 1'b1;
					else
						buf_q <= WDATA;
				end
			end
			if (buf_rd)
				stat_q[`SSP_STAT_FULL] <= 1'b0;
			if (spi_done) begin
				buf_q <= spi_rx;
				stat_q[`SSP_STAT_FULL] <= 1'b1;
				flags_q[`SSP_FLAGS_IRQ] <= 1'b1;
				WAKE <= SLEEPING;
			end
			if (i2c_full) begin
				buf_q <= i2c_rx;
				stat_q[`SSP_STAT_FULL] <= 1'b1;
			end
			if (i2c_ack)
				flags_q[`SSP_FLAGS_IRQ] <= 1'b1;
			if (i2c_ua)
				stat_q[`SSP_STAT_UPD] <= 1'b1;
			if (i2c_start_seen)
				stat_q[`SSP_STAT_S] <= 1'b1;
			if (i2c_start_done || (i2c_coll && !i2c_in_start))
				ctrl2_q[`SSP_CTRL2_START] <= 1'b0;
			if (i2c_coll)
				flags_q[`SSP_FLAGS_BCL] <= 1'b1;
			if (RD) begin
				if (is_addr(ADDR, `SSP_OFF_FLAGS))
					RDATA <= flags_q;
				else if (is_addr(ADDR, `SSP_OFF_ENABLES))
					RDATA <= enables_q;
				else if (is_addr(ADDR, `SSP_OFF_CTRL))
					RDATA <= ctrl_q;
				else if (is_addr(ADDR, `SSP_OFF_CTRL2))
					RDATA <= ctrl2_q;
				else if (is_addr(ADDR, `SSP_OFF_STAT))
					RDATA <= stat_q;
				else if (is_addr(ADDR, `SSP_OFF_ADDR))
					RDATA <= addr_q;
				else if (buf_rd)
					RDATA <= buf_q;
				else
					RDATA <= 8'h00;
			end else begin
				RDATA <= 8'h00;
			end
		end
	end

	// pin muxing: port enable hands pins to the serial function
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			SCK_O <= 1'b0;
			SCK_OE <= 1'b0;
			SDO_O <= 1'b0;
			SDO_OE <= 1'b0;
			SCL_O <= 1'b0;
			SCL_OE <= 1'b0;
			SDA_O <= 1'b0;
			SDA_OE <= 1'b0;
		end else begin
			SCK_O <= spi_sck;
			SCK_OE <= spi_on && spi_master;
			SDO_O <= spi_sdo;
			SDO_OE <= spi_on && !ss_reset;
			// open drain: only ever pull low
			SCL_O <= 1'b0;
			SCL_OE <= 1'b0;
			SDA_O <= 1'b0;
			SDA_OE <= en && is_i2c && i2c_sda_low;
		end
	end
endmodule

/* pkg/ssp_regs.vh */
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// register offsets on the 8-bit register port
`define SSP_OFF_FLAGS       8'h0C
`define SSP_OFF_BUF         8'h13
`define SSP_OFF_CTRL        8'h14
`define SSP_OFF_ENABLES     8'h8C
`define SSP_OFF_CTRL2       8'h91
`define SSP_OFF_ADDR        8'h93
`define SSP_OFF_STAT        8'h94
// reset values
`define SSP_RST_FLAGS       8'h00
`define SSP_RST_ENABLES     8'h00
`define SSP_RST_CTRL        8'h00
`define SSP_RST_CTRL2       8'h00
`define SSP_RST_STAT        8'h00
`define SSP_RST_ADDR        8'h00
// field positions
`define SSP_CTRL_WRCOL      7
`define SSP_CTRL_IDLE       4
`define SSP_CTRL_EN         5
`define SSP_STAT_LATE       7
`define SSP_STAT_CKE        6
`define SSP_STAT_S          3
`define SSP_STAT_UPD        1
`define SSP_STAT_FULL       0
`define SSP_CTRL2_GCALL     7
`define SSP_CTRL2_START     0
`define SSP_FLAGS_IRQ       3
`define SSP_FLAGS_BCL       4
// mode field encodings
`define SSP_MODE_M_DIV4     4'h0
`define SSP_MODE_M_DIV16    4'h1
`define SSP_MODE_M_DIV64    4'h2
`define SSP_MODE_S_SS       4'h4
`define SSP_MODE_S_NOSS     4'h5
`define SSP_MODE_I2C_S7     4'h6
`define SSP_MODE_I2C_S10    4'h7
`define SSP_MODE_I2C_M      4'h8
`define SSP_MODE_I2C_S7B    4'hE
`define SSP_MODE_I2C_S10B   4'hF
`define SSP_BITS            4'h8
`endif

/* rtl/ssp_spi.v */
`timescale 1ns/1ps
`include "ssp_regs.vh"
// spi shift engine: master or slave, all four clock modes
module ssp_spi (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       master,
	input  wire       idle_lvl,
	input  wire       cke,
	input  wire       late_smp,
	input  wire [1:0] rate,
	input  wire       load,
	input  wire [7:0] load_data,
	input  wire       sck_in,
	input  wire       sdi_in,
	input  wire       ss_reset,
	output reg        sck_out,
	output reg        sdo_out,
	output reg  [7:0] rx_data,
	output reg        done
);
	reg  [7:0] sr_q;
	reg  [3:0] cnt_q;
	reg        busy_q;
	reg  [6:0] div_q;
	reg        sck_prev_q;
	reg        half_q;
	reg        smp_bit_q;
	wire [6:0] div_end;
	wire       tick;
	wire       lead;
	wire       trail;
	wire       bit_in;
	wire [7:0] sr_next;

	// master half period of 2, 8 or 32 cycles
	assign div_end = (rate == 2'h0) ? 7'h01 : (rate == 2'h1) ? 7'h07 : 7'h1F;
	assign tick = busy_q && master && (div_q == div_end);
	// leading / trailing edges relative to idle level
	assign lead = master ? (tick && !half_q) : (sck_prev_q == idle_lvl && sck_in != idle_lvl);
	assign trail = master ? (tick && half_q) : (sck_prev_q != idle_lvl && sck_in == idle_lvl);
	// every bit cell closes on the trailing edge; cke=1 samples right there
	assign bit_in = (cke || (late_smp && master)) ? sdi_in : smp_bit_q;
	assign sr_next = {sr_q[6:0], bit_in};

	always @(posedge clk) begin
		if (!rst_n || !enable) begin
			sr_q <= 8'h00;
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			div_q <= 7'h00;
			sck_prev_q <= idle_lvl;
			half_q <= 1'b0;
			smp_bit_q <= 1'b0;
			sck_out <= 1'b0;
			sdo_out <= 1'b0;
			rx_data <= 8'h00;
			done <= 1'b0;
		end else if (ss_reset) begin
			// bit counter restarts; a word already loaded waits for the next frame
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			div_q <= 7'h00;
			sck_prev_q <= idle_lvl;
			half_q <= 1'b0;
			smp_bit_q <= 1'b0;
			done <= 1'b0;
			if (load) begin
				sr_q <= load_data;
				if (!cke)
					sdo_out <= load_data[7];
			end
		end else begin
			done <= 1'b0;
			sck_prev_q <= sck_in;
			if (!busy_q)
				sck_out <= idle_lvl;
			if (master)
				div_q <= tick ? 7'h00 : (busy_q ? div_q + 7'h01 : 7'h00);
			if (load) begin
				sr_q <= load_data;
				busy_q <= master;
				cnt_q <= 4'h0;
				half_q <= 1'b0;
				if (!cke)
					sdo_out <= load_data[7];
			end else begin
				if (tick) begin
					half_q <= ~half_q;
					sck_out <= ~sck_out;
				end
				if (!cke && lead)
					smp_bit_q <= sdi_in;
				if (cke && lead)
					sdo_out <= sr_q[7];
				if (trail) begin
					// both directions move together
					sr_q <= sr_next;
					if (!cke)
						sdo_out <= sr_q[6];
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `SSP_BITS - 4'h1) begin
						rx_data <= sr_next;
						done <= 1'b1;
						busy_q <= 1'b0;
						cnt_q <= 4'h0;
					end
				end
			end
			if (!master)
				busy_q <= 1'b0;
		end
	end
endmodule

/* rtl/ssp_i2c.v */
`timescale 1ns/1ps
`include "ssp_regs.vh"
// i2c: general call slave address stage and master start generation
module ssp_i2c (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       ten_bit,
	input  wire       master,
	input  wire       gcall_en,
	input  wire [7:0] addr,
	input  wire       start_req,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_low,
	output reg        start_seen,
	output reg        start_done,
	output reg        collision,
	output reg        in_start,
	output reg  [7:0] rx_byte,
	output reg        byte_full,
	output reg        ack_irq,
	output reg        upd_set
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT1 = 2'h1;
	localparam ST_WAIT2 = 2'h2;
	reg  [1:0] st_q;
	reg  [6:0] brg_q;
	reg  [7:0] sr_q;
	reg  [3:0] bit_q;
	reg        scl_p_q;
	reg        sda_p_q;
	reg        active_q;
	reg        gc_q;
	reg        skip_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_cond;

	assign scl_rise = scl_in && !scl_p_q;
	assign scl_fall = !scl_in && scl_p_q;
	assign start_cond = scl_in && sda_p_q && !sda_in;

	always @(posedge clk) begin
		if (!rst_n || !enable) begin
			st_q <= ST_IDLE;
			brg_q <= 7'h00;
			sr_q <= 8'h00;
			bit_q <= 4'h0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			active_q <= 1'b0;
			gc_q <= 1'b0;
			skip_q <= 1'b0;
			sda_low <= 1'b0;
			start_seen <= 1'b0;
			start_done <= 1'b0;
			collision <= 1'b0;
			in_start <= 1'b0;
			rx_byte <= 8'h00;
			byte_full <= 1'b0;
			ack_irq <= 1'b0;
			upd_set <= 1'b0;
		end else begin
			scl_p_q <= scl_in;
			sda_p_q <= sda_in;
			start_seen <= 1'b0;
			start_done <= 1'b0;
			collision <= 1'b0;
			byte_full <= 1'b0;
			ack_irq <= 1'b0;
			upd_set <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (master && start_req) begin
					if (scl_in && sda_in) begin
						brg_q <= addr[6:0];
						st_q <= ST_WAIT1;
						in_start <= 1'b1;
					end else begin
						collision <= 1'b1;
					end
				end
			end
			ST_WAIT1: begin
				if (!scl_in) begin
					collision <= 1'b1;
					in_start <= 1'b0;
					st_q <= ST_IDLE;
				end else if (brg_q == 7'h00) begin
					if (sda_in) begin
						sda_low <= 1'b1;
						start_seen <= 1'b1;
						brg_q <= addr[6:0];
						st_q <= ST_WAIT2;
					end else begin
						collision <= 1'b1;
						in_start <= 1'b0;
						st_q <= ST_IDLE;
					end
				end else begin
					brg_q <= brg_q - 7'h01;
				end
			end
			ST_WAIT2: begin
				if (brg_q == 7'h00) begin
					start_done <= 1'b1;
					in_start <= 1'b0;
					st_q <= ST_IDLE;
				end else begin
					brg_q <= brg_q - 7'h01;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
			// slave address stage
			if (!master) begin
				if (start_cond) begin
					active_q <= 1'b1;
					bit_q <= 4'h0;
					gc_q <= 1'b0;
				end else if (active_q && scl_rise && bit_q < `SSP_BITS) begin
					sr_q <= {sr_q[6:0], sda_in};
					bit_q <= bit_q + 4'h1;
					if (bit_q == `SSP_BITS - 4'h1) begin
						if (gcall_en && {sr_q[6:0], sda_in} == 8'h00) begin
							rx_byte <= 8'h00;
							byte_full <= 1'b1;
							gc_q <= 1'b1;
							skip_q <= ten_bit;
						end else if ({sr_q[6:0], sda_in} == addr) begin
							rx_byte <= {sr_q[6:0], sda_in};
							byte_full <= 1'b1;
							gc_q <= 1'b1;
							skip_q <= 1'b0;
						end else begin
							active_q <= 1'b0;
						end
					end
				end else if (active_q && scl_fall && bit_q == `SSP_BITS) begin
					bit_q <= bit_q + 4'h1;
				end else if (active_q && scl_fall && bit_q == `SSP_BITS + 4'h1) begin
					if (gc_q) begin
						ack_irq <= 1'b1;
						upd_set <= ten_bit && !skip_q;
					end
					active_q <= 1'b0;
				end
			end
		end
	end
endmodule

/* verification/ssp_top_asserts.sv */
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_asserts (
	input wire       CLK_SYS,
	input wire       RST_N,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	input wire       SLEEPING,
	input wire       WAKE,
	input wire       SCK_OE,
	input wire       SDO_OE,
	input wire       SS_N_I,
	input wire       SCL_I,
	input wire       SDA_I,
	input wire       SCL_OE,
	input wire       SDA_OE
);
	reg  [7:0] ctrl_q;
	reg  [6:0] rate_q;
	reg  [8:0] sen_cnt_q;
	reg  [3:0] ss_cnt_q;
	wire       off = !ctrl_q[5];
	wire       slv = ctrl_q[5] && (ctrl_q[3:0] == 4'h4 || ctrl_q[3:0] == 4'h5);
	wire       unmapped = !(ADDR == `SSP_OFF_FLAGS || ADDR == `SSP_OFF_BUF
		|| ADDR == `SSP_OFF_CTRL || ADDR == `SSP_OFF_ENABLES || ADDR == `SSP_OFF_CTRL2
		|| ADDR == `SSP_OFF_ADDR || ADDR == `SSP_OFF_STAT);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// software view only: bits set by hardware are not mirrored
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl_q    <= 8'h00;
			rate_q    <= 7'h00;
			sen_cnt_q <= 9'h1FF;
			ss_cnt_q  <= 4'h0;
		end else begin
			if (WR && ADDR == `SSP_OFF_CTRL)
				ctrl_q <= WDATA;
			if (WR && ADDR == `SSP_OFF_ADDR)
				rate_q <= WDATA[6:0];
			if (WR && ADDR == `SSP_OFF_CTRL2 && WDATA[0])
				sen_cnt_q <= 9'h000;
			else if (sen_cnt_q != 9'h1FF)
				sen_cnt_q <= sen_cnt_q + 9'h001;
			if (ctrl_q[5] && ctrl_q[3:0] == 4'h4 && SS_N_I)
				ss_cnt_q <= (ss_cnt_q == 4'hF) ? ss_cnt_q : ss_cnt_q + 4'h1;
			else
				ss_cnt_q <= 4'h0;
		end
	end
	AST_RDATA_IDLE: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not zero outside a read answer");
	AST_UNMAPPED_ZERO: assert property (RD && unmapped |=> RDATA == 8'h00)
		else $error("unmapped read returned data");
	AST_WAKE_PULSE: assert property (WAKE |-> $past(SLEEPING) ##1 !WAKE)
		else $error("wake without sleep or longer than one cycle");
	AST_SLAVE_SCK_IN: assert property (slv && $past(slv) && $past(slv, 2) |-> !SCK_OE)
		else $error("slave drives the serial clock");
	AST_OFF_QUIET: assert property (off && $past(off) && $past(off, 2) |-> !(SCK_OE || SDO_OE || SDA_OE))
		else $error("pins driven while port disabled");
	AST_SS_HOLD: assert property (ss_cnt_q > 4'h3 |-> !WAKE)
		else $error("byte completed while select held high");
	AST_START_TIME: assert property ($rose(SDA_OE) |-> sen_cnt_q > rate_q && sen_cnt_q < rate_q + 9'h007)
		else $error("start edge not one generator period after request");
	AST_START_LINES: assert property ($rose(SDA_OE) |-> $past(SCL_I, 3) && $past(SDA_I, 3))
		else $error("start driven with a bus line low");
	AST_START_HOLD: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
		else $error("data line not held low after start");
	AST_SDA_MASTER: assert property ($rose(SDA_OE) |-> ctrl_q[5] && ctrl_q[3:0] == 4'h8)
		else $error("start driven outside i2c master mode");
	AST_SCL_FREE: assert property (!SCL_OE)
		else $error("clock line pulled low");
	cover property (WAKE);
	cover property ($rose(SDA_OE));
	cover property (RD && unmapped);
endmodule
bind ssp_top ssp_asserts u_asserts (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEPING(SLEEPING), .WAKE(WAKE),
	.SCK_OE(SCK_OE), .SDO_OE(SDO_OE), .SS_N_I(SS_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
	.SCL_OE(SCL_OE), .SDA_OE(SDA_OE));

/* verification/ssp_far_dev.sv */
`timescale 1ns/1ps
// far side: spi master with 160 ns and i2c master with 320 ns link period
module ssp_far_dev (
	output reg  sck,
	output reg  mosi,
	output reg  ss_n,
	input  wire miso,
	output reg  scl_l,
	output reg  sda_l
);
	initial begin
		sck   = 1'h0;
		mosi  = 1'h0;
		ss_n  = 1'h1;
		scl_l = 1'h0;
		sda_l = 1'h0;
	end
	// clock stands at idle level, frame bracketed by select
	// drive on the leading edge, sample well after the trailing one
	task spi_xfer(input [7:0] tx, input idle_lvl, input integer n, output [7:0] rx);
		integer k;
		begin
			sck = idle_lvl;
			rx  = 8'h00;
			#160 ss_n = 1'h0;
			for (k = 0; k < n; k = k + 1) begin
				#40 sck = ~idle_lvl;
				mosi = tx[7 - k];
				#80 sck = idle_lvl;
				#40 rx = {rx[6:0], miso};
			end
			#160 ss_n = 1'h1;
			// released line must not keep the last bit
			mosi = ~mosi;
		end
	endtask
	task i2c_addr(input [7:0] b);
		integer k;
		begin
			#160 sda_l = 1'h1;
			#160 scl_l = 1'h1;
			for (k = 0; k < 9; k = k + 1) begin
				sda_l = (k < 8) ? ~b[7 - k] : 1'h0;
				#160 scl_l = 1'h0;
				#160 scl_l = 1'h1;
			end
			sda_l = 1'h1;
			#160 scl_l = 1'h0;
			#160 sda_l = 1'h0;
		end
	endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "ssp_regs.vh"
module testbench;
	reg         clk, rst_n, wr, rd, sleeping, loop_en, scl_hold, rd_q;
	reg  [7:0]  addr, wdata, tx, rx, prx;
	reg  [7:0]  exp_q[$];
	reg  [7:0]  msk_q[$];
	integer     fail_count, checks, cyc, seed, wakes, i;
	wire [7:0]  rdata;
	wire        wake, sck_o, sck_oe, sdo_o, sdo_oe, scl_o, scl_oe, sda_o, sda_oe;
	wire        f_sck, f_mosi, f_ss_n, f_scl_l, f_sda_l;
	localparam [55:0] OFFS = 56'h0C8C14919394_55;
	ssp_far_dev far (.sck(f_sck), .mosi(f_mosi), .ss_n(f_ss_n), .miso(sdo_o),
		.scl_l(f_scl_l), .sda_l(f_sda_l));
	ssp_top uut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SLEEPING(sleeping), .WAKE(wake), .SCK_I(f_sck), .SCK_O(sck_o),
		.SCK_OE(sck_oe), .SDI_I(loop_en ? sdo_o : f_mosi), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
		.SS_N_I(f_ss_n), .SCL_I(~(f_scl_l | scl_hold | scl_oe)), .SCL_O(scl_o),
		.SCL_OE(scl_oe), .SDA_I(~(f_sda_l | sda_oe)), .SDA_O(sda_o), .SDA_OE(sda_oe));
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	task check(input string nm, input [7:0] seen, input [7:0] expv);
		begin
			checks = checks + 1;
			if (seen !== expv) begin
				fail_count = fail_count + 1;
				$display("[ERR] %s expected %h seen %h", nm, expv, seen);
			end
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'h1;
			@(posedge clk);
			wr <= 1'h0;
			@(posedge clk);
		end
	endtask
	// expectation noted now, compared when the answer appears
	task rd_reg(input [7:0] a, input [7:0] e, input [7:0] m);
		begin
			exp_q.push_back(e);
			msk_q.push_back(m);
			addr <= a;
			rd <= 1'h1;
			@(posedge clk);
			rd <= 1'h0;
			@(posedge clk);
		end
	endtask
	always @(posedge clk) begin
		rd_q <= rd;
		cyc = cyc + 1;
		if (wake === 1'h1)
			wakes = wakes + 1;
		if (rd_q)
			check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			summarize;
		end
	end
	initial begin
		seed = 32'h5166;
		{addr, wdata, wr, rd, rd_q, rst_n, sleeping, loop_en, scl_hold} = 0;
		{fail_count, checks, cyc, wakes} = 0;
		idle(16);
		rst_n <= 1'h1;
		@(posedge clk);
		for (i = 0; i < 7; i = i + 1)
			rd_reg(OFFS[55 - i * 8 -: 8], 8'h00, 8'hFF);
		tx = $random(seed);
		wr_reg(`SSP_OFF_ENABLES, tx);
		rd_reg(`SSP_OFF_ENABLES, tx, 8'hFF);
		// master loops its own output back; sample at end of bit
		loop_en <= 1'h1;
		wr_reg(`SSP_OFF_STAT, 8'h80);
		for (i = 0; i < 3; i = i + 1) begin
			tx = $random(seed);
			wr_reg(`SSP_OFF_CTRL, 8'h20 | i[7:0]);
			wr_reg(`SSP_OFF_BUF, tx);
			check("sck oe", {7'h00, sck_oe}, 8'h01);
			idle((32 << (2 * i)) + 40);
			rd_reg(`SSP_OFF_FLAGS, 8'h08, 8'h08);
			rd_reg(`SSP_OFF_BUF, tx, 8'hFF);
			wr_reg(`SSP_OFF_FLAGS, 8'h00);
			wr_reg(`SSP_OFF_CTRL, 8'h00);
		end
		loop_en <= 1'h0;
		sleeping <= 1'h1;
		wr_reg(`SSP_OFF_STAT, 8'h40);
		for (i = 0; i < 2; i = i + 1) begin
			tx = $random(seed);
			rx = $random(seed);
			prx = $random(seed);
			wr_reg(`SSP_OFF_CTRL, 8'h24 | (i[7:0] << 4));
			wr_reg(`SSP_OFF_BUF, tx);
			wakes = 0;
			if (i == 1)
				far.spi_xfer(prx, 1'h1, 3, prx);
			far.spi_xfer(rx, i[0], 8, prx);
			@(posedge clk);
			idle(4);
			if (i == 0)
				check("far rx", prx, tx);
			check("wake", wakes[7:0], 8'h01);
			check("sck oe", {7'h00, sck_oe}, 8'h00);
			rd_reg(`SSP_OFF_FLAGS, 8'h08, 8'h08);
			rd_reg(`SSP_OFF_BUF, rx, 8'hFF);
			wr_reg(`SSP_OFF_FLAGS, 8'h00);
			wr_reg(`SSP_OFF_CTRL, 8'h00);
		end
		sleeping <= 1'h0;
		wr_reg(`SSP_OFF_ADDR, 8'h10);
		wr_reg(`SSP_OFF_CTRL, 8'h28);
		wr_reg(`SSP_OFF_CTRL2, 8'h01);
		wr_reg(`SSP_OFF_BUF, 8'h5A);
		wr_reg(`SSP_OFF_CTRL2, 8'h1E);
		idle(60);
		check("sda oe", {7'h00, sda_oe}, 8'h01);
		rd_reg(`SSP_OFF_STAT, 8'h08, 8'h08);
		rd_reg(`SSP_OFF_CTRL2, 8'h00, 8'h1F);
		rd_reg(`SSP_OFF_CTRL, 8'h80, 8'h80);
		rd_reg(`SSP_OFF_BUF, rx, 8'hFF);
		wr_reg(`SSP_OFF_CTRL, 8'h00);
		wr_reg(`SSP_OFF_CTRL, 8'h28);
		scl_hold <= 1'h1;
		idle(4);
		wr_reg(`SSP_OFF_CTRL2, 8'h01);
		idle(60);
		check("sda oe", {7'h00, sda_oe}, 8'h00);
		rd_reg(`SSP_OFF_FLAGS, 8'h10, 8'h10);
		scl_hold <= 1'h0;
		for (i = 1; i >= 0; i = i - 1) begin
			wr_reg(`SSP_OFF_CTRL, 8'h00);
			wr_reg(`SSP_OFF_FLAGS, 8'h00);
			wr_reg(`SSP_OFF_CTRL2, {i[0], 7'h00});
			wr_reg(`SSP_OFF_CTRL, 8'h27);
			far.i2c_addr(8'h00);
			@(posedge clk);
			idle(4);
			rd_reg(`SSP_OFF_STAT, {7'h00, i[0]}, 8'h03);
			rd_reg(`SSP_OFF_FLAGS, {4'h0, i[0], 3'h0}, 8'h08);
			if (i == 1)
				rd_reg(`SSP_OFF_BUF, 8'h00, 8'hFF);
		end
		// ten-bit first address byte matching the programmed address
		wr_reg(`SSP_OFF_CTRL, 8'h00);
		wr_reg(`SSP_OFF_ADDR, 8'hF0);
		wr_reg(`SSP_OFF_CTRL, 8'h27);
		far.i2c_addr(8'hF0);
		@(posedge clk);
		idle(4);
		rd_reg(`SSP_OFF_STAT, 8'h03, 8'h03);
		rd_reg(`SSP_OFF_BUF, 8'hF0, 8'hFF);
		idle(2);
		summarize;
	end
endmodule
